// *** verilog/mmd_pkg.sv ***
// mmd_pkg: constants and types for the memory map decoder
// assumes a 16-bit byte-addressed core bus with 8-bit data
package mmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address regions
  localparam logic [15:0] IO_LO      = 16'h0000;
  localparam logic [15:0] IO_HI      = 16'h007F;
  localparam logic [15:0] XIO_A_LO   = 16'h0E00;
  localparam logic [15:0] XIO_A_HI   = 16'h0EFF;
  localparam logic [15:0] XIO_B_LO   = 16'h0F80;
  localparam logic [15:0] XIO_B_HI   = 16'h0FFF;
  localparam logic [15:0] DIR_LO     = 16'h0090;
  localparam logic [15:0] DIR_HI     = 16'h00FF;
  localparam logic [15:0] XDIR_HI    = 16'h047F;
  localparam logic [15:0] GPR_LO     = 16'h0100;
  localparam logic [15:0] GPR_HI     = 16'h01FF;
  localparam logic [15:0] NVR_LO     = 16'hFFBB;
  localparam logic [15:0] NVR_HI     = 16'hFFBF;
  localparam logic [15:0] VEC_LO     = 16'hFFC0;
  localparam logic [15:0] VEC_HI     = 16'hFFFF;
  localparam logic [15:0] BANK_BASE  = 16'h0080;
  localparam logic [7:0]  BANK_OPLO  = 8'h80;
  localparam logic [2:0]  DBP_RESET  = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // i/o register offsets
  localparam logic [6:0] A_P0_DATA  = 7'h00;
  localparam logic [6:0] A_P0_DIR   = 7'h01;
  localparam logic [6:0] A_P1_DATA  = 7'h02;
  localparam logic [6:0] A_P1_DIR   = 7'h03;
  localparam logic [6:0] A_OSC_WAIT = 7'h05;
  localparam logic [6:0] A_PLL      = 7'h06;
  localparam logic [6:0] A_SYSCLK   = 7'h07;
  localparam logic [6:0] A_STBY     = 7'h08;
  localparam logic [6:0] A_RSTCAUSE = 7'h09;
  localparam logic [6:0] A_TBT      = 7'h0A;
  localparam logic [6:0] A_WPRE     = 7'h0B;
  localparam logic [6:0] A_WDOG     = 7'h0C;
  localparam logic [6:0] A_SYSCLK2  = 7'h0D;
  localparam logic [6:0] A_P4_DATA  = 7'h12;
  localparam logic [6:0] A_P4_DIR   = 7'h13;
  localparam logic [6:0] A_P6_DATA  = 7'h16;
  localparam logic [6:0] A_P6_DIR   = 7'h17;
  localparam logic [6:0] A_P7_DATA  = 7'h18;
  localparam logic [6:0] A_P7_DIR   = 7'h19;
  localparam logic [6:0] A_STBY2    = 7'h1C;
  localparam logic [6:0] A_PF_DATA  = 7'h28;
  localparam logic [6:0] A_PF_DIR   = 7'h29;
  localparam logic [6:0] A_PG_DATA  = 7'h2A;
  localparam logic [6:0] A_PG_DIR   = 7'h2B;
  localparam logic [6:0] A_P0_PULL  = 7'h2C;
  localparam logic [6:0] A_P1_PULL  = 7'h2D;
  localparam logic [6:0] A_BANKSEL  = 7'h78;

  ////////////////////////////////////////////////////////////////////////////
  // reset values (unknown documented bits taken as zero)
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_OSCW   = 8'hFF;
  localparam logic [7:0] RST_SYSCLK = 8'h1B;
  localparam logic [7:0] RST_SYSC2  = 8'h03;
  localparam logic [4:0] RBP_RESET  = 5'h00;

  // bank select mirror layout: [7:3] register bank, [2:0] direct bank
  localparam int BANKSEL_DBP_MSB = 2;
  localparam int BANKSEL_RBP_LSB = 3;

  ////////////////////////////////////////////////////////////////////////////
  // region codes
  typedef enum logic [2:0] {
    MMD_RGN_NONE = 3'b000,
    MMD_RGN_IO   = 3'b001,
    MMD_RGN_XIO  = 3'b010,
    MMD_RGN_RAM  = 3'b011,
    MMD_RGN_GPR  = 3'b100,
    MMD_RGN_NVR  = 3'b101,
    MMD_RGN_VEC  = 3'b110,
    MMD_RGN_PROG = 3'b111
  } mmd_region_e;

  // one core access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        direct;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmd_req_s;

  // decode result
  typedef struct packed {
    mmd_region_e region;
    logic [15:0] phys;
  } mmd_map_s;

endpackage

// *** verilog/mmd_decoder.sv ***
// mmd_decoder: memory map decoder and low i/o register bank
// assumes the core presents one access per cycle on core_clk, same domain
//
// Function
// - The space is one linear 64 Kbyte map reached by 16-bit addresses holding i/o, extended i/o, data and program.
// - Addresses 0x0000 to 0x007F decode to peripheral registers reachable by normal and direct accesses.
// - Ranges 0x0E00-0x0EFF and 0x0F80-0x0FFF go to extended i/o, memory accesses only.
// - RAM 0x0090 to 0x00FF is reachable by direct and by normal accesses.
// - Addresses 0x0100 to 0x047F are the extended direct area reached through the direct bank pointer.
// - Addresses 0x0100 to 0x01FF are the general-purpose register area and decode to a region of their own, not RAM.
// - Vector fetches come from 0xFFC0 to 0xFFFF at the top of flash.
// - Flash 0xFFBB to 0xFFBF holds non-volatile register data, apart from code and vectors.
// - Direct operands 0x0000 to 0x007F map unchanged to i/o whatever the bank pointer holds.
// - The direct bank pointer is 3 bits, resets to zero, and at zero maps operands 0x0090-0x00FF to themselves.
// - Pointer values one to seven relocate operands 0x0080-0x00FF to 0x0100 plus 0x80 per step above one.
// - Address 0x0078 mirrors the register and direct bank pointers for reading and writing.
`timescale 1ns/1ps

module mmd_decoder (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire mmd_pkg::mmd_req_s req,
  output mmd_pkg::mmd_map_s      map,
  output logic                   io_sel,
  output logic                   dir_illegal,
  output logic [7:0]             io_rdata,
  output logic [2:0]             direct_bank_pointer,
  output logic [4:0]             register_bank_pointer,
  output logic [7:0]             port0_data,
  output logic [7:0]             port0_direction,
  output logic [7:0]             port1_data,
  output logic [7:0]             port1_direction,
  output logic [7:0]             port4_data,
  output logic [7:0]             port4_direction,
  output logic [7:0]             port6_data,
  output logic [7:0]             port6_direction,
  output logic [7:0]             port7_data,
  output logic [7:0]             port7_direction,
  output logic [7:0]             port_f_data,
  output logic [7:0]             port_f_direction,
  output logic [7:0]             port_g_data,
  output logic [7:0]             port_g_direction,
  output logic [7:0]             port0_pullup,
  output logic [7:0]             port1_pullup,
  output logic [7:0]             osc_stabilization_wait,
  output logic [7:0]             pll_control,
  output logic [7:0]             system_clock_control,
  output logic [7:0]             standby_control,
  output logic [7:0]             reset_cause,
  output logic [7:0]             timebase_timer_control,
  output logic [7:0]             watch_prescaler_control,
  output logic [7:0]             watchdog_control,
  output logic [7:0]             system_clock_control_second,
  output logic [7:0]             standby_control_second
);

  ////////////////////////////////////////////////////////////////////////////
  // region classification of a physical address
  function automatic mmd_pkg::mmd_region_e classify(input logic [15:0] a);
    mmd_pkg::mmd_region_e r;
    r = mmd_pkg::MMD_RGN_NONE;
    if (a <= mmd_pkg::IO_HI)
      r = mmd_pkg::MMD_RGN_IO;
    else if ((a >= mmd_pkg::XIO_A_LO && a <= mmd_pkg::XIO_A_HI) ||
             (a >= mmd_pkg::XIO_B_LO && a <= mmd_pkg::XIO_B_HI))
      r = mmd_pkg::MMD_RGN_XIO;
    else if (a >= mmd_pkg::GPR_LO && a <= mmd_pkg::GPR_HI)
      r = mmd_pkg::MMD_RGN_GPR;
    else if (a >= mmd_pkg::DIR_LO && a <= mmd_pkg::XDIR_HI)
      r = mmd_pkg::MMD_RGN_RAM;
    else if (a >= mmd_pkg::NVR_LO && a <= mmd_pkg::NVR_HI)
      r = mmd_pkg::MMD_RGN_NVR;
    else if (a >= mmd_pkg::VEC_LO)
      r = mmd_pkg::MMD_RGN_VEC;
    else if (a > mmd_pkg::XIO_B_HI)
      r = mmd_pkg::MMD_RGN_PROG;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // direct operand relocation
  logic [2:0]  dbp_q;
  logic [4:0]  rbp_q;
  logic [15:0] phys;
  logic [7:0]  op;

  assign op = req.addr[7:0];

  always_comb begin
    phys        = req.addr;
    dir_illegal = 1'b0;
    if (req.direct) begin
      if (op <= mmd_pkg::IO_HI[7:0])
        phys = {8'h00, op};
      else if (dbp_q != mmd_pkg::DBP_RESET)
        phys = mmd_pkg::BANK_BASE + {5'h00, dbp_q, 8'h00} / 16'd2 + {8'h00, op - mmd_pkg::BANK_OPLO};
      else begin
        phys        = {8'h00, op};
        dir_illegal = (op < mmd_pkg::DIR_LO[7:0]);
      end
    end
  end

  always_comb begin
    map.phys   = phys;
    map.region = classify(phys);
  end

  // i/o select for normal or direct accesses
  assign io_sel = req.valid && (map.region == mmd_pkg::MMD_RGN_IO) && !dir_illegal;

  ////////////////////////////////////////////////////////////////////////////
  // i/o register bank, 128 slots
  logic [7:0] regs_q [0:127];
  logic [6:0] ofs;
  logic       wr;

  assign ofs = phys[6:0];
  assign wr  = io_sel && req.write;

  function automatic logic implemented(input logic [6:0] o);
    return (o <= mmd_pkg::A_P1_DIR) || (o >= mmd_pkg::A_OSC_WAIT && o <= mmd_pkg::A_SYSCLK2) ||
           (o == mmd_pkg::A_P4_DATA) || (o == mmd_pkg::A_P4_DIR) ||
           (o >= mmd_pkg::A_P6_DATA && o <= mmd_pkg::A_P7_DIR) || (o == mmd_pkg::A_STBY2) ||
           (o >= mmd_pkg::A_PF_DATA && o <= mmd_pkg::A_P1_PULL);
  endfunction

  function automatic logic [7:0] reset_of(input logic [6:0] o);
    logic [7:0] v;
    v = mmd_pkg::RST_ZERO;
    if (o == mmd_pkg::A_OSC_WAIT)
      v = mmd_pkg::RST_OSCW;
    else if (o == mmd_pkg::A_SYSCLK)
      v = mmd_pkg::RST_SYSCLK;
    else if (o == mmd_pkg::A_SYSCLK2)
      v = mmd_pkg::RST_SYSC2;
    return v;
  endfunction

  // one flop per implemented slot; unused slots stay constant
  // unused slots never written
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++) begin : g_slot
      if (implemented(7'(gi))) begin : g_reg
        logic [7:0] slot_q;
        always_ff @(posedge core_clk or negedge nrst) begin
          if (!nrst)
            slot_q <= reset_of(7'(gi));
          else if (wr && ofs == 7'(gi))
            slot_q <= req.wdata;
        end
        assign regs_q[gi] = slot_q;
      end else begin : g_void
        assign regs_q[gi] = 8'h00;
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dbp_q <= mmd_pkg::DBP_RESET;
      rbp_q <= mmd_pkg::RBP_RESET;
    end else if (wr && ofs == mmd_pkg::A_BANKSEL) begin
      dbp_q <= req.wdata[mmd_pkg::BANKSEL_DBP_MSB:0];
      rbp_q <= req.wdata[7:mmd_pkg::BANKSEL_RBP_LSB];
    end
  end

  // registered read data; unused reads zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      io_rdata <= 8'h00;
    else if (io_sel && !req.write)
      io_rdata <= (ofs == mmd_pkg::A_BANKSEL) ? {rbp_q, dbp_q} : regs_q[ofs];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register outputs
  assign direct_bank_pointer         = dbp_q;
  assign register_bank_pointer       = rbp_q;
  assign port0_data                  = regs_q[mmd_pkg::A_P0_DATA];
  assign port0_direction             = regs_q[mmd_pkg::A_P0_DIR];
  assign port1_data                  = regs_q[mmd_pkg::A_P1_DATA];
  assign port1_direction             = regs_q[mmd_pkg::A_P1_DIR];
  assign port4_data                  = regs_q[mmd_pkg::A_P4_DATA];
  assign port4_direction             = regs_q[mmd_pkg::A_P4_DIR];
  assign port6_data                  = regs_q[mmd_pkg::A_P6_DATA];
  assign port6_direction             = regs_q[mmd_pkg::A_P6_DIR];
  assign port7_data                  = regs_q[mmd_pkg::A_P7_DATA];
  assign port7_direction             = regs_q[mmd_pkg::A_P7_DIR];
  assign port_f_data                 = regs_q[mmd_pkg::A_PF_DATA];
  assign port_f_direction            = regs_q[mmd_pkg::A_PF_DIR];
  assign port_g_data                 = regs_q[mmd_pkg::A_PG_DATA];
  assign port_g_direction            = regs_q[mmd_pkg::A_PG_DIR];
  assign port0_pullup                = regs_q[mmd_pkg::A_P0_PULL];
  assign port1_pullup                = regs_q[mmd_pkg::A_P1_PULL];
  assign osc_stabilization_wait      = regs_q[mmd_pkg::A_OSC_WAIT];
  assign pll_control                 = regs_q[mmd_pkg::A_PLL];
  assign system_clock_control        = regs_q[mmd_pkg::A_SYSCLK];
  assign standby_control             = regs_q[mmd_pkg::A_STBY];
  assign reset_cause                 = regs_q[mmd_pkg::A_RSTCAUSE];
  assign timebase_timer_control      = regs_q[mmd_pkg::A_TBT];
  assign watch_prescaler_control     = regs_q[mmd_pkg::A_WPRE];
  assign watchdog_control            = regs_q[mmd_pkg::A_WDOG];
  assign system_clock_control_second = regs_q[mmd_pkg::A_SYSCLK2];
  assign standby_control_second      = regs_q[mmd_pkg::A_STBY2];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_io_passthru: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7:0] <= 8'h7F) |-> (map.phys == {8'h00, req.addr[7:0]}))
    else $error("direct i/o operand relocated");

  chk_bank_window: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7] && dbp_q != 3'd0) |->
      (map.phys == 16'h0080 + {5'h00, dbp_q, 7'h00} + {9'h000, req.addr[6:0]}))
    else $error("bank window address wrong");

  chk_bank_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7:0] >= 8'h90 && dbp_q == 3'd0) |-> (map.phys == {8'h00, req.addr[7:0]}))
    else $error("bank zero not identity");

  chk_io_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr <= 16'h007F) |-> (map.region == mmd_pkg::MMD_RGN_IO))
    else $error("i/o area not decoded");

  chk_xio_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr[15:8] == 8'h0E) |-> (map.region == mmd_pkg::MMD_RGN_XIO))
    else $error("extended i/o not decoded");

  chk_vec_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'hFFC0) |-> (map.region == mmd_pkg::MMD_RGN_VEC))
    else $error("vector table not decoded");

  chk_nvr_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'hFFBB && req.addr <= 16'hFFBF) |-> (map.region == mmd_pkg::MMD_RGN_NVR))
    else $error("nonvolatile area not decoded");

  chk_gpr_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr[15:8] == 8'h01) |-> (map.region == mmd_pkg::MMD_RGN_GPR))
    else $error("register area not decoded");

  chk_mirror_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (io_sel && req.write && map.phys == 16'h0078) |=> ({rbp_q, dbp_q} == $past(req.wdata)))
    else $error("bank mirror not written");

  chk_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    (io_sel && !req.write && map.phys == 16'h0004) |=> (io_rdata == 8'h00))
    else $error("unused i/o read nonzero");

  chk_ram_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'h0090 && req.addr <= 16'h00FF) |-> (map.region == mmd_pkg::MMD_RGN_RAM))
    else $error("direct ram not decoded");

  chk_xdir_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'h0200 && req.addr <= 16'h047F) |-> (map.region == mmd_pkg::MMD_RGN_RAM))
    else $error("extended direct ram not decoded");

  chk_xio_upper: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'h0F80 && req.addr <= 16'h0FFF) |-> (map.region == mmd_pkg::MMD_RGN_XIO))
    else $error("upper extended i/o not decoded");

  chk_xio_no_direct: assert property (@(posedge core_clk) disable iff (!nrst)
    req.direct |-> (map.region != mmd_pkg::MMD_RGN_XIO))
    else $error("direct access reached extended i/o");

  chk_direct_io_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.valid && req.direct && req.addr[7:0] <= 8'h7F) |-> io_sel)
    else $error("direct i/o access not selected");

  chk_io_sel_valid: assert property (@(posedge core_clk) disable iff (!nrst)
    io_sel |-> (req.valid && map.phys <= 16'h007F))
    else $error("i/o select outside i/o area");

  chk_gap_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'h0480 && req.addr <= 16'h0DFF) |-> (map.region == mmd_pkg::MMD_RGN_NONE))
    else $error("unmapped gap decoded");

  chk_prog_region: assert property (@(posedge core_clk) disable iff (!nrst)
    (!req.direct && req.addr >= 16'h1000 && req.addr <= 16'hFFBA) |-> (map.region == mmd_pkg::MMD_RGN_PROG))
    else $error("program area not decoded");

  chk_window_range: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7] && dbp_q != 3'd0) |-> (map.phys >= 16'h0100 && map.phys <= 16'h047F))
    else $error("bank window outside extended ram");

  chk_bank_one: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7:0] == 8'h80 && dbp_q == 3'd1) |-> (map.phys == 16'h0100))
    else $error("first bank window base wrong");

  chk_bank_seven: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7:0] == 8'hFF && dbp_q == 3'd7) |-> (map.phys == 16'h047F))
    else $error("last bank window top wrong");

  chk_gpr_window: assert property (@(posedge core_clk) disable iff (!nrst)
    (req.direct && req.addr[7] && (dbp_q == 3'd1 || dbp_q == 3'd2)) |-> (map.region == mmd_pkg::MMD_RGN_GPR))
    else $error("low bank windows miss register area");

  chk_illegal_cause: assert property (@(posedge core_clk) disable iff (!nrst)
    dir_illegal |-> (req.direct && dbp_q == 3'd0 && req.addr[7:0] >= 8'h80 && req.addr[7:0] < 8'h90))
    else $error("illegal flag without cause");

  chk_illegal_no_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    dir_illegal |-> !io_sel)
    else $error("illegal direct operand selected i/o");

  chk_vec_top: assert property (@(posedge core_clk) disable iff (!nrst)
    (map.region == mmd_pkg::MMD_RGN_VEC) |-> (map.phys >= 16'hFFC0))
    else $error("vector region below table");

  chk_nvr_bounds: assert property (@(posedge core_clk) disable iff (!nrst)
    (map.region == mmd_pkg::MMD_RGN_NVR) |-> (map.phys >= 16'hFFBB && map.phys <= 16'hFFBF))
    else $error("nonvolatile region out of bounds");

  chk_io_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (io_sel && req.write && map.phys == 16'h0000) |=> (port0_data == $past(req.wdata)))
    else $error("port register not written");

  chk_direct_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (io_sel && req.write && req.direct && req.addr[7:0] == 8'h02) |=> (port1_data == $past(req.wdata)))
    else $error("direct i/o write lost");

  chk_mirror_read: assert property (@(posedge core_clk) disable iff (!nrst)
    (io_sel && !req.write && map.phys == 16'h0078) |=> (io_rdata == {rbp_q, dbp_q}))
    else $error("bank mirror read wrong");

  chk_rdata_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !(io_sel && !req.write) |=> $stable(io_rdata))
    else $error("read data moved without a read");

  chk_pointer_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !(io_sel && req.write && map.phys == 16'h0078) |=> ($stable(dbp_q) && $stable(rbp_q)))
    else $error("bank pointers moved without a write");

  chk_unused_stable: assert property (@(posedge core_clk) disable iff (!nrst)
    (io_sel && req.write && map.phys == 16'h0004) |=> ($stable(port0_data) && $stable(osc_stabilization_wait)))
    else $error("unused write disturbed a register");

endmodule

// *** verif/mmd_core_model.sv ***
// mmd_core_model: behavioural core that issues memory and direct accesses
// assumes the decoder samples req on the rising core_clk edge
`timescale 1ns/1ps

module mmd_core_model (
  input  wire logic              core_clk,
  input  wire logic [7:0]        io_rdata,
  output mmd_pkg::mmd_req_s      req
);
  initial req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // present one access just after the falling edge
  task automatic drive(input logic w, input logic d, input logic [15:0] a, input logic [7:0] wd);
    @(negedge core_clk);
    req <= '{valid: 1'b1, write: w, direct: d, addr: a, wdata: wd};
  endtask

  // release: inverted leftovers so no stale value passes for a live one
  task automatic idle();
    @(negedge core_clk);
    req <= '{valid: 1'b0, write: ~req.write, direct: ~req.direct, addr: ~req.addr, wdata: ~req.wdata};
  endtask

  // full access, read data taken one edge after the request edge
  task automatic acc(input logic w, input logic d, input logic [15:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    drive(w, d, a, wd);
    idle();
    rd = io_rdata;
  endtask
endmodule

// *** verif/memory_map_decoder_test.sv ***
// memory_map_decoder_test: self-checking bench for the decoder and i/o bank
// assumes mmd_pkg is compiled first and the core model drives req
`timescale 1ns/1ps

module memory_map_decoder_test;
  logic                core_clk = 1'b0;
  logic                nrst     = 1'b0;
  mmd_pkg::mmd_req_s   req;
  mmd_pkg::mmd_map_s   map;
  logic                io_sel, dir_illegal;
  logic [7:0]          io_rdata, rd;
  logic [7:0]          outs [26];
  logic [2:0]          dbp;
  logic [4:0]          rbp;
  int                  fail_count = 0;
  int                  num_checks = 0;
  int                  cycles = 0;
  localparam logic [6:0] OFFS [26] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09,
    7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h12, 7'h13, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1C, 7'h28, 7'h29,
    7'h2A, 7'h2B, 7'h2C, 7'h2D};
  localparam logic [15:0] RADDR [14] = '{16'h0000, 16'h007F, 16'h0090, 16'h047F, 16'h0100, 16'h01FF,
    16'h0480, 16'h0E00, 16'h0F00, 16'h0FFF, 16'h1000, 16'hFFBB, 16'hFFBF, 16'hFFC0};
  localparam logic [2:0] RGN [14] = '{3'h1, 3'h1, 3'h3, 3'h3, 3'h4, 3'h4, 3'h0, 3'h2, 3'h0, 3'h2,
    3'h7, 3'h5, 3'h5, 3'h6};
  localparam logic [6:0] UNUSED [4] = '{7'h04, 7'h0E, 7'h1D, 7'h31};

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  mmd_decoder uut (
    .core_clk(core_clk), .nrst(nrst), .req(req), .map(map), .io_sel(io_sel), .dir_illegal(dir_illegal),
    .io_rdata(io_rdata), .direct_bank_pointer(dbp), .register_bank_pointer(rbp), .port0_data(outs[0]),
    .port0_direction(outs[1]), .port1_data(outs[2]), .port1_direction(outs[3]), .port4_data(outs[13]),
    .port4_direction(outs[14]), .port6_data(outs[15]), .port6_direction(outs[16]), .port7_data(outs[17]),
    .port7_direction(outs[18]), .port_f_data(outs[20]), .port_f_direction(outs[21]),
    .port_g_data(outs[22]), .port_g_direction(outs[23]), .port0_pullup(outs[24]), .port1_pullup(outs[25]),
    .osc_stabilization_wait(outs[4]), .pll_control(outs[5]), .system_clock_control(outs[6]),
    .standby_control(outs[7]), .reset_cause(outs[8]), .timebase_timer_control(outs[9]),
    .watch_prescaler_control(outs[10]), .watchdog_control(outs[11]),
    .system_clock_control_second(outs[12]), .standby_control_second(outs[19])
  );

  mmd_core_model core (.core_clk(core_clk), .io_rdata(io_rdata), .req(req));

  ////////////////////////////////////////////////////////////////////////////
  // comparison, reset table and verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rst_of(input logic [6:0] off);
    return (off == 7'h05) ? 8'hFF : (off == 7'h07) ? 8'h1B : (off == 7'h0D) ? 8'h03 : 8'h00;
  endfunction

  // hold a request, look at the decode while it stands, then release
  task automatic probe(input logic d, input logic [15:0] a, input logic [15:0] ph, input logic sel,
                       input logic chk_rg, input logic [2:0] rg);
    core.drive(1'b0, d, a, 8'h00);
    #10;
    check(map.phys, ph);
    check({15'h0, io_sel}, {15'h0, sel});
    if (chk_rg) begin
      check({13'h0, map.region}, {13'h0, rg});
    end
    core.idle();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < 26; i++) begin
      core.acc(1'b0, 1'b0, {9'h0, OFFS[i]}, 8'h00, rd);
      check({8'h0, rd}, {8'h0, rst_of(OFFS[i])});
      check({8'h0, outs[i]}, {8'h0, rst_of(OFFS[i])});
    end
    check({13'h0, dbp}, 16'h0000);
    check({11'h0, rbp}, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 26; i++) begin
      core.acc(1'b1, 1'b0, {9'h0, OFFS[i]}, {1'b0, OFFS[i]} ^ 8'hA5, rd);
      check({8'h0, outs[i]}, {8'h0, {1'b0, OFFS[i]} ^ 8'hA5});
    end
    for (int i = 0; i < 26; i++) begin
      core.acc(1'b0, 1'b0, {9'h0, OFFS[i]}, 8'h00, rd);
      check({8'h0, rd}, {8'h0, {1'b0, OFFS[i]} ^ 8'hA5});
    end
    for (int i = 0; i < 4; i++) begin
      core.acc(1'b1, 1'b0, {9'h0, UNUSED[i]}, 8'hFF, rd);
      core.acc(1'b0, 1'b0, {9'h0, UNUSED[i]}, 8'h00, rd);
      check({8'h0, rd}, 16'h0000);
    end
    for (int i = 0; i < 26; i++) begin
      check({8'h0, outs[i]}, {8'h0, {1'b0, OFFS[i]} ^ 8'hA5});
    end
    core.acc(1'b1, 1'b0, 16'h0100, 8'h3C, rd);
    core.acc(1'b1, 1'b1, 16'h0080, 8'h3C, rd);
    check({8'h0, outs[0]}, 16'h00A5);
    check({13'h0, dbp}, 16'h0000);
    $display("test register access done");
    core.acc(1'b1, 1'b0, 16'h0078, 8'hAB, rd);
    check({11'h0, rbp}, 16'h0015);
    check({13'h0, dbp}, 16'h0003);
    core.acc(1'b0, 1'b0, 16'h0078, 8'h00, rd);
    check({8'h0, rd}, 16'h00AB);
    $display("test bank mirror done");
    for (int k = 0; k < 8; k++) begin
      core.acc(1'b1, 1'b0, 16'h0078, {5'h0A, k[2:0]}, rd);
      probe(1'b1, 16'hFF05, 16'h0005, 1'b1, 1'b0, 3'h0);
      if (k == 0) begin
        probe(1'b1, 16'h0095, 16'h0095, 1'b0, 1'b0, 3'h0);
        core.drive(1'b0, 1'b1, 16'h0085, 8'h00);
        #10;
        check({15'h0, dir_illegal}, 16'h0001);
        core.idle();
      end else begin
        probe(1'b1, 16'h0085, 16'h0085 + 16'(k) * 16'h0080, 1'b0, 1'b0, 3'h0);
      end
    end
    core.acc(1'b1, 1'b1, 16'h0002, 8'h6E, rd);
    check({8'h0, outs[2]}, 16'h006E);
    $display("test direct mapping done");
    for (int i = 0; i < 14; i++) begin
      probe(1'b0, RADDR[i], RADDR[i], (i < 2), 1'b1, RGN[i]);
    end
    $display("test region decode done");
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    check({13'h0, dbp}, 16'h0000);
    check({11'h0, rbp}, 16'h0000);
    for (int i = 0; i < 26; i++) begin
      check({8'h0, outs[i]}, {8'h0, rst_of(OFFS[i])});
    end
    core.acc(1'b0, 1'b0, 16'h0005, 8'h00, rd);
    check({8'h0, rd}, 16'h00FF);
    $display("test second reset done");
    give_verdict();
  end
endmodule
